// ==== hdl/irq_ctrl_pkg.sv ====
// Shared constants and types for the two-level interrupt controller
package irq_ctrl_pkg;

  localparam int          NUM_SRC         = 40;
  localparam int          PC_W            = 21;
  localparam logic [20:0] HIGH_VECTOR     = 21'h000008;
  localparam logic [20:0] LOW_VECTOR      = 21'h000018;
  localparam int          PRIO_EN_BIT     = 7;
  localparam int          GIE_HIGH_BIT    = 7;
  localparam int          GIE_LOW_BIT     = 6;
  localparam logic        PRIO_EN_RESET   = 1'b0;
  localparam logic [1:0]  GIE_RESET       = 2'b00;
  localparam int          STACK_DEPTH     = 31;
  localparam int          SYNC_STAGES     = 2;
  localparam int          LATENCY_MIN     = 3;
  localparam int          LATENCY_MAX     = 4;
  localparam int          CTRL_REG_COUNT  = 19;

  typedef struct packed {
    logic             take;
    logic             high;
    logic [20:0]      vector;
  } vector_req_t;

  typedef struct packed {
    logic             in_high;
    logic             in_low;
  } service_state_t;

endpackage

// ==== hdl/irq_flag_bank.sv ====
// Event flags for every source: set by events, cleared by software writes
`timescale 1ns/100ps
module irq_flag_bank #(
  parameter int N = 40
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [N-1:0] event_pulse,
  input  wire logic [N-1:0] flag_clear,
  output logic      [N-1:0] flag_q
);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          flag_q[g] <= 1'b0;
        end else if (event_pulse[g]) begin
          flag_q[g] <= 1'b1;
        end else if (flag_clear[g]) begin
          flag_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // irq_flag_bank

// ==== hdl/irq_return_stack.sv ====
// Hardware return-address stack shared by interrupt entry and return
`timescale 1ns/100ps
module irq_return_stack #(
  parameter int W     = 21,
  parameter int DEPTH = 31
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         push,
  input  wire logic [W-1:0] push_addr,
  input  wire logic         pop,
  output logic      [W-1:0] top_q,
  output logic              overflow_q
);

  logic [W-1:0]             mem [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] ptr_q;

  always_ff @(posedge clk) begin
    if (push && ptr_q < DEPTH[$clog2(DEPTH+1)-1:0]) begin
      mem[ptr_q] <= push_addr;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q      <= '0;
      overflow_q <= 1'b0;
    end else if (push && !pop) begin
      if (ptr_q < DEPTH[$clog2(DEPTH+1)-1:0]) begin
        ptr_q <= ptr_q + 1'b1;
      end else begin
        // Full stack drops the address instead of wrapping over live entries
        overflow_q <= 1'b1;
      end
    end else if (pop && !push && ptr_q != '0) begin
      ptr_q <= ptr_q - 1'b1;
    end
  end

  assign top_q = (ptr_q == '0) ? '0 : mem[ptr_q - 1'b1];

endmodule // irq_return_stack

// ==== hdl/irq_controller.sv ====
// Two-level prioritised interrupt controller facing the core sequencer
`timescale 1ns/100ps
module irq_controller #(
  parameter int N_SRC = irq_ctrl_pkg::NUM_SRC
) (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic [N_SRC-1:0]              src_event,
  input  wire logic [N_SRC-1:0]              src_is_periph,
  input  wire logic [N_SRC-1:0]              src_enable,
  input  wire logic [N_SRC-1:0]              src_priority_high,
  input  wire logic [N_SRC-1:0]              flag_clear,
  input  wire logic                          priority_levels_enable_wr,
  input  wire logic                          priority_levels_enable_in,
  input  wire logic                          gie_wr,
  input  wire logic [1:0]                    gie_in,
  input  wire logic                          instr_boundary,
  input  wire logic                          return_from_irq_instr,
  input  wire logic [irq_ctrl_pkg::PC_W-1:0] return_pc,
  output logic      [N_SRC-1:0]              flag_out,
  output logic                               priority_levels_enable,
  output logic                               high_level_global_enable,
  output logic                               low_level_global_enable,
  output irq_ctrl_pkg::vector_req_t          vector_out,
  output logic      [irq_ctrl_pkg::PC_W-1:0] resume_pc,
  output logic                               in_high_service,
  output logic                               in_low_service,
  output logic                               stack_overflow
);
  import irq_ctrl_pkg::*;

  // Bit 7 doubles as the single global enable, bit 6 as the peripheral enable
  logic [N_SRC-1:0]   flag_q;
  logic               prio_q;
  logic               gie_h_q;
  logic               gie_l_q;
  service_state_t     svc_q;
  vector_req_t        vec_q;
  logic [PC_W-1:0]    resume_q;
  logic               take_high;
  logic               take_low;
  logic               want_high;
  logic               want_low;
  logic [N_SRC-1:0]   active;
  logic [N_SRC-1:0]   eff_high;
  logic [PC_W-1:0]    stack_top;
  logic               stack_ovf;
  logic               accept;
  logic [PC_W-1:0]    accept_vector;
  logic               nest_q;
  logic               stack_pop;

  // flag, enable and priority ports stand in for the control registers
  irq_flag_bank #(
    .N (N_SRC)
  ) u_flags (
    .clk         (clk),
    .rst_b       (rst_b),
    .event_pulse (src_event),
    .flag_clear  (flag_clear),
    .flag_q      (flag_q)
  );

  irq_return_stack #(
    .W     (PC_W),
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .clk        (clk),
    .rst_b      (rst_b),
    .push       (accept),
    .push_addr  (return_pc),
    .pop        (stack_pop),
    .top_q      (stack_top),
    .overflow_q (stack_ovf)
  );

  // flag and enable combine per source
  assign active   = flag_q & src_enable;
  // priority bits ignored outside priority mode
  assign eff_high = prio_q ? src_priority_high : {N_SRC{1'b1}};

  always_comb begin
    want_high = 1'b0;
    want_low  = 1'b0;
    if (prio_q) begin
      // high global enable gates high sources
      want_high = gie_h_q && |(active & eff_high) && !svc_q.in_high;
      // low global enable gates low sources
      // no low service while high runs
      want_low  = gie_l_q && |(active & ~eff_high) && !svc_q.in_high && !svc_q.in_low;
    end else begin
      // bit 7 all sources, bit 6 peripherals
      want_high = gie_h_q && |(active & (~src_is_periph | {N_SRC{gie_l_q}}))
                  && !svc_q.in_high;
    end
  end

  // vector at the first instruction boundary
  // high wins a tie, low left pending
  // high may enter over a running low routine
  assign take_high = instr_boundary && want_high && !vec_q.take;
  assign take_low  = instr_boundary && want_low && !want_high && !vec_q.take;
  assign accept    = take_high || take_low;
  // A return that meets an acceptance is dropped, so the stack never pushes and pops at once
  assign stack_pop = return_from_irq_instr && !accept;

  assign accept_vector = (take_low && prio_q) ? LOW_VECTOR : HIGH_VECTOR;

  // priority mode bit, cleared by reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prio_q <= PRIO_EN_RESET;
    end else if (priority_levels_enable_wr) begin
      prio_q <= priority_levels_enable_in;
    end
  end

  // clear enable in use on acceptance
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gie_h_q <= GIE_RESET[1];
      gie_l_q <= GIE_RESET[0];
    end else if (accept) begin
      if (take_high) begin
        gie_h_q <= 1'b0;
      end else begin
        gie_l_q <= 1'b0;
      end
    end else if (return_from_irq_instr) begin
      if (!prio_q || svc_q.in_high) begin
        gie_h_q <= 1'b1;
        if (!nest_q && prio_q && svc_q.in_low) begin
          gie_l_q <= gie_l_q;
        end
      end else begin
        gie_l_q <= 1'b1;
      end
    end else if (gie_wr) begin
      gie_h_q <= gie_in[1];
      gie_l_q <= gie_in[0];
    end
  end

  // Tracks whether a high routine sits on top of a low one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      svc_q  <= '0;
      nest_q <= 1'b0;
    end else if (accept) begin
      if (take_high) begin
        nest_q       <= svc_q.in_low;
        svc_q.in_high <= 1'b1;
      end else begin
        svc_q.in_low <= 1'b1;
      end
    end else if (return_from_irq_instr) begin
      if (svc_q.in_high) begin
        svc_q.in_high <= 1'b0;
        nest_q        <= 1'b0;
      end else begin
        svc_q.in_low <= 1'b0;
      end
    end
  end

  // event to vector within the pipeline depth
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_q    <= '0;
      resume_q <= '0;
    end else begin
      vec_q.take <= accept;
      if (accept) begin
        vec_q.high   <= take_high;
        vec_q.vector <= accept_vector;
      end
      if (stack_pop) begin
        resume_q <= stack_top;
      end
    end
  end

  assign flag_out                 = flag_q;
  assign priority_levels_enable   = prio_q;
  assign high_level_global_enable = gie_h_q;
  assign low_level_global_enable  = gie_l_q;
  assign vector_out               = vec_q;
  assign resume_pc                = resume_q;
  assign in_high_service          = svc_q.in_high;
  assign in_low_service           = svc_q.in_low;
  assign stack_overflow           = stack_ovf;

  sequence s_high_accept;
    take_high;
  endsequence

  sequence s_vector_high;
    vector_out.take && vector_out.high && vector_out.vector == HIGH_VECTOR;
  endsequence

  chk_high_vector_addr: assert property (@(posedge clk) disable iff (!rst_b)
    s_high_accept |=> s_vector_high) else $error("high vector address wrong");

  chk_low_vector_addr: assert property (@(posedge clk) disable iff (!rst_b)
    take_low && prio_q |=> vector_out.vector == LOW_VECTOR) else $error("low vector wrong");

  chk_compat_vector: assert property (@(posedge clk) disable iff (!rst_b)
    accept && !prio_q |=> vector_out.vector == HIGH_VECTOR) else $error("compat vector wrong");

  chk_gie_cleared: assert property (@(posedge clk) disable iff (!rst_b)
    take_high |=> !high_level_global_enable) else $error("global enable not cleared");

  chk_low_blocked: assert property (@(posedge clk) disable iff (!rst_b)
    in_high_service |-> !take_low) else $error("low taken during high service");

  chk_tie_high_first: assert property (@(posedge clk) disable iff (!rst_b)
    want_high && want_low && instr_boundary && !vec_q.take |-> take_high && !take_low)
    else $error("tie not resolved to high");

  chk_reti_sets_gie: assert property (@(posedge clk) disable iff (!rst_b)
    return_from_irq_instr && !accept && !prio_q |=> high_level_global_enable)
    else $error("return did not re-enable");

  chk_preempt_low: assert property (@(posedge clk) disable iff (!rst_b)
    in_low_service && !in_high_service && want_high && instr_boundary && !vec_q.take
    |=> in_high_service && in_low_service) else $error("high did not preempt low");

  chk_flag_sets: assert property (@(posedge clk) disable iff (!rst_b)
    src_event != '0 |=> (flag_out & $past(src_event)) == $past(src_event))
    else $error("flag not set on event");

  chk_vector_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    vector_out.take |=> !vector_out.take) else $error("vector strobe longer than a cycle");

  chk_prio_reset: assert property (@(posedge clk) disable iff (!rst_b)
    !$past(rst_b) |-> !priority_levels_enable) else $error("priority mode set at reset");

  sequence s_low_accept;
    take_low && prio_q;
  endsequence

  sequence s_vector_low;
    vector_out.take && !vector_out.high && vector_out.vector == LOW_VECTOR;
  endsequence

  sequence s_return_from_high;
    return_from_irq_instr && !accept && prio_q && svc_q.in_high;
  endsequence

  sequence s_return_from_low;
    return_from_irq_instr && !accept && prio_q && !svc_q.in_high && svc_q.in_low;
  endsequence

  // Fresh event on a source that the single enable alone lets through
  sequence s_fresh_event;
    |(src_event & src_enable & ~src_is_periph) && !prio_q && gie_h_q && !svc_q.in_high
    && !accept && !gie_wr && !priority_levels_enable_wr;
  endsequence

  sequence s_boundary_next;
    instr_boundary && $stable(src_enable) && $stable(src_is_periph);
  endsequence

  chk_low_vector_seq: assert property (@(posedge clk) disable iff (!rst_b)
    s_low_accept |=> s_vector_low) else $error("low entry strobe wrong");

  chk_low_gie_cleared: assert property (@(posedge clk) disable iff (!rst_b)
    take_low |=> !low_level_global_enable && in_low_service)
    else $error("low global enable not cleared");

  chk_compat_all_gate: assert property (@(posedge clk) disable iff (!rst_b)
    !prio_q && !high_level_global_enable |-> !accept) else $error("bit 7 did not gate");

  chk_compat_periph: assert property (@(posedge clk) disable iff (!rst_b)
    !prio_q && !low_level_global_enable && (flag_out & src_enable & ~src_is_periph) == '0
    |-> !accept) else $error("peripheral taken with bit 6 clear");

  chk_high_gated: assert property (@(posedge clk) disable iff (!rst_b)
    prio_q && !high_level_global_enable |-> !take_high) else $error("high taken while gated");

  chk_low_gated: assert property (@(posedge clk) disable iff (!rst_b)
    prio_q && !low_level_global_enable |-> !take_low) else $error("low taken while gated");

  chk_push_on_accept: assert property (@(posedge clk) disable iff (!rst_b)
    accept |=> stack_overflow || stack_top == $past(return_pc))
    else $error("return address not on stack top");

  chk_resume_from_top: assert property (@(posedge clk) disable iff (!rst_b)
    stack_pop |=> resume_pc == $past(stack_top)) else $error("resume address wrong");

  chk_reti_high_level: assert property (@(posedge clk) disable iff (!rst_b)
    s_return_from_high |=> high_level_global_enable && !in_high_service)
    else $error("high return did not re-enable");

  chk_reti_low_level: assert property (@(posedge clk) disable iff (!rst_b)
    s_return_from_low |=> low_level_global_enable && !in_low_service)
    else $error("low return did not re-enable");

  chk_event_latency: assert property (@(posedge clk) disable iff (!rst_b)
    s_fresh_event ##1 s_boundary_next |=> vector_out.take && vector_out.vector == HIGH_VECTOR)
    else $error("event to vector too slow");

endmodule // irq_controller

// ==== tb/core_model.sv ====
// Behavioural core sequencer that feeds boundaries and returns to the controller
`timescale 1ns/100ps
module core_model
  import irq_ctrl_pkg::*;
#(
  parameter logic [20:0] START_PC = 21'h000100
) (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      slow,
  input  wire logic                      ret_req,
  input  wire irq_ctrl_pkg::vector_req_t vector_out,
  input  wire logic [PC_W-1:0]           resume_pc,
  output logic                           instr_boundary,
  output logic                           return_from_irq_instr,
  output logic      [PC_W-1:0]           return_pc
);
  logic [1:0] gap_q;
  logic       ret_seen_q;

  // Slow mode mimics three-cycle instructions: a boundary every third cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= 2'h0;
      instr_boundary <= 1'b0;
      return_from_irq_instr <= 1'b0;
      ret_seen_q <= 1'b0;
      return_pc <= START_PC;
    end else begin
      gap_q <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
      instr_boundary <= !slow || (gap_q == 2'h0);
      return_from_irq_instr <= ret_req;
      ret_seen_q <= return_from_irq_instr;
      // service code runs past the vector; return resumes at stack top
      if (vector_out.take) begin
        return_pc <= vector_out.vector + 21'h000002;
      end else if (ret_seen_q) begin
        return_pc <= resume_pc;
      end
    end
  end
endmodule // core_model

// ==== tb/two_level_interrupt_controller_bench.sv ====
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/100ps
module two_level_interrupt_controller_bench;
  import irq_ctrl_pkg::*;
  logic               clk, rst_b, slow, ret_req, pwr, pin, gwr, bnd, rti;
  logic [1:0]         gin;
  logic [NUM_SRC-1:0] ev, periph, en, prio, fclr, flags;
  logic [PC_W-1:0]    rpc, resume;
  logic               plen, gh, gl, inh, inl, ovf;
  vector_req_t        vo;
  logic [20:0]        exp_q[$];
  int                 err_total, samples_checked, hi, lo, n;

  always #10 clk = ~clk;

  irq_controller #(.N_SRC(NUM_SRC)) dut_u (
    .clk(clk), .rst_b(rst_b), .src_event(ev), .src_is_periph(periph), .src_enable(en),
    .src_priority_high(prio), .flag_clear(fclr), .priority_levels_enable_wr(pwr),
    .priority_levels_enable_in(pin), .gie_wr(gwr), .gie_in(gin), .instr_boundary(bnd),
    .return_from_irq_instr(rti), .return_pc(rpc), .flag_out(flags),
    .priority_levels_enable(plen), .high_level_global_enable(gh),
    .low_level_global_enable(gl), .vector_out(vo), .resume_pc(resume),
    .in_high_service(inh), .in_low_service(inl), .stack_overflow(ovf));

  core_model core_u (
    .clk(clk), .rst_b(rst_b), .slow(slow), .ret_req(ret_req), .vector_out(vo),
    .resume_pc(resume), .instr_boundary(bnd), .return_from_irq_instr(rti),
    .return_pc(rpc));

  task automatic results;
    $display("checked=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic fire(input logic [NUM_SRC-1:0] m);
    ev = m;
    cyc(1);
    ev = '0;
  endtask

  // enables change by one plain write, never a two-step move
  task automatic wr_gie(input logic [1:0] v);
    gin = v;
    gwr = 1'b1;
    cyc(1);
    gwr = 1'b0;
  endtask

  task automatic clr(input logic [NUM_SRC-1:0] m);
    fclr = m;
    cyc(1);
    fclr = '0;
  endtask

  task automatic ret;
    ret_req = 1'b1;
    cyc(1);
    ret_req = 1'b0;
    cyc(5);
  endtask

  // Every take must match the oldest noted vector; a stray take is a refusal missed
  task automatic drain(output int c);
    c = 0;
    while (exp_q.size() != 0 && c < 40) begin
      cyc(1);
      c++;
    end
    if (exp_q.size() != 0) begin
      err_total++;
      results();
    end
  endtask

  always @(negedge clk) begin
    if (rst_b === 1'b1 && vo.take === 1'b1) begin
      if (exp_q.size() == 0) chk({11'h0, vo.vector}, 32'h0);
      else chk({11'h0, vo.vector}, {11'h0, exp_q.pop_front()});
    end
  end

  initial begin
    clk = 1'b0; rst_b = 1'b0; slow = 1'b0; ret_req = 1'b0; pwr = 1'b0; pin = 1'b0;
    gwr = 1'b0; gin = 2'b00; ev = '0; periph = '0; en = '0; prio = '0; fclr = '0;
    err_total = 0; samples_checked = 0;
    void'($urandom(79));
    hi = $urandom_range(NUM_SRC - 1, 0);
    lo = (hi + 1 + $urandom_range(NUM_SRC - 2, 0)) % NUM_SRC;
    en[hi] = 1'b1; en[lo] = 1'b1; periph[lo] = 1'b1;
    prio[hi] = 1'($urandom); prio[lo] = 1'($urandom);
    cyc(5);
    rst_b = 1'b1;
    cyc(1);
    chk({29'h0, plen, gh, gl}, 32'h0);
    fire(NUM_SRC'(1) << hi);
    cyc(3);
    chk({31'h0, flags[hi]}, 32'h1);
    clr('1);
    wr_gie(2'b11);
    exp_q.push_back(HIGH_VECTOR);
    fire(NUM_SRC'(1) << hi);
    drain(n);
    chk({31'h0, n <= LATENCY_MAX}, 32'h1);
    chk({30'h0, gh, inh}, 32'h1);
    clr('1);
    ret();
    chk({11'h0, resume}, 32'h100);
    chk({31'h0, gh}, 32'h1);
    wr_gie(2'b10);
    fire(NUM_SRC'(1) << lo);
    cyc(10);
    exp_q.push_back(HIGH_VECTOR);
    wr_gie(2'b11);
    drain(n);
    clr('1);
    ret();
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    chk({30'h0, gh, plen}, 32'h0);
    pin = 1'b1;
    pwr = 1'b1;
    cyc(1);
    pwr = 1'b0;
    chk({31'h0, plen}, 32'h1);
    slow = 1'b1;
    prio[hi] = 1'b1; prio[lo] = 1'b0;
    wr_gie(2'b11);
    exp_q.push_back(HIGH_VECTOR);
    fire((NUM_SRC'(1) << hi) | (NUM_SRC'(1) << lo));
    drain(n);
    chk({31'h0, vo.high}, 32'h1);
    chk({30'h0, gh, gl}, 32'h1);
    cyc(12);
    clr(NUM_SRC'(1) << hi);
    exp_q.push_back(LOW_VECTOR);
    ret();
    drain(n);
    chk({31'h0, vo.high}, 32'h0);
    chk({29'h0, gh, gl, inl}, 32'h5);
    exp_q.push_back(HIGH_VECTOR);
    fire(NUM_SRC'(1) << hi);
    drain(n);
    clr(NUM_SRC'(1) << hi);
    ret();
    chk({11'h0, resume}, {11'h0, LOW_VECTOR + 21'h000002});
    chk({30'h0, gh, inl}, 32'h3);
    clr(NUM_SRC'(1) << lo);
    ret();
    chk({10'h0, gl, resume}, 32'h200100);
    chk({31'h0, ovf}, 32'h0);
    results();
  end
endmodule // two_level_interrupt_controller_bench
